// ==== src/cimw_pkg.sv ====
package cimw_pkg;
    // Command codes of the two words
    localparam logic [7:0] CMD_CAPABILITY = 8'h11;
    localparam logic [7:0] CMD_MODE = 8'h12;
    // Capability word: version field low, selector flag, reserved zero
    localparam logic [3:0] SPEC_VERSION_FIELD = 4'h1;
    localparam int SELECTOR_CAPABILITY_BIT = 4;
    localparam logic [15:0] CAPABILITY_VALUE = 16'h0001;
    // Mode word field positions
    localparam int MODE_HALT_BIT = 0;
    localparam int MODE_RESTORE_BIT = 2;
    localparam int MODE_MAINS_MASK_BIT = 4;
    localparam int MODE_PACK_MASK_BIT = 5;
    localparam int MODE_SOURCE_MASK_BIT = 6;
    localparam int MODE_CUTOFF_BIT = 10;
    // Only these bits are kept; restore bit 2 acts as a strobe, the rest are ignored
    localparam logic [15:0] MODE_KEEP_MASK = 16'h0471;
    // Power-on value: masks and halt clear, cutoff enabled
    localparam logic [15:0] MODE_RESET = 16'h0400;
    // Defaults loaded by restore and at power-on
    localparam logic [15:0] VOLTAGE_DEFAULT = 16'hFFFF;
    localparam logic [15:0] CURRENT_DEFAULT = 16'h00C0;
    // Status pin positions in the synchronised vector
    localparam int ST_MAINS = 0;
    localparam int ST_PACK = 1;
    localparam int ST_SOURCE = 2;
    localparam int ST_OVERHEAT = 3;
    localparam int ST_COUNT = 4;

    // Completed, acknowledged write-word from the framing logic
    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [15:0] data;
    } cimw_wr_t;

    // Read-word request from the framing logic
    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
    } cimw_rd_t;
endpackage

// ==== src/cimw_top.sv ====
`timescale 1ns/100ps
// Function
// RULE1: capability read returns version code in bits 3:0
// RULE2: selector bit and reserved bits read zero
// RULE3: mode bit 0 sets or clears halt
// RULE4: only mode writes change the halt latch
// RULE5: restore loads voltage 0xFFFF, current 0x00C0
// RULE6: restore also clears overheat and alarm latches
// RULE7: mains change interrupts unless bit 4 set
// RULE8: pack change interrupts unless bit 5 set
// RULE9: source-below-pack change interrupts unless bit 6 set
// RULE10: bit 10 lets overheat latch stop charging
// RULE11: overheat cleared by restore or pack absent
// RULE12: power-on: bits 0,4,5,6 zero, bit 10 one
// RULE13: host uses write-word and read-word, low byte first
// RULE14: unimplemented mode bits are ignored
// RULE15: only complete acknowledged writes take effect
module cimw_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Transactions from the serial framing logic
    input wire cimw_pkg::cimw_wr_t wr_i,
    input wire cimw_pkg::cimw_rd_t rd_i,
    // Status pins from the analog side
    input wire logic mains_detected_i,
    input wire logic pack_detected_i,
    input wire logic source_below_pack_i,
    input wire logic overheat_detect_i,
    // Alarm-block set from the watchdog logic
    input wire logic alarm_set_i,
    // Read answer
    output logic rd_valid_o,
    output logic rd_hit_o,
    output logic [15:0] rd_data_o,
    // Charger control
    output logic charge_halt_o,
    output logic charger_off_o,
    output logic overheat_latch_o,
    output logic alarm_block_o,
    output logic [15:0] voltage_setpoint_o,
    output logic [15:0] current_setpoint_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////
    // Status pin synchronisers

    logic [cimw_pkg::ST_COUNT-1:0] st_meta; // First stage, read by sync only
    logic [cimw_pkg::ST_COUNT-1:0] st_sync; // Safe copy
    logic [cimw_pkg::ST_COUNT-1:0] st_prev; // For change detect
    logic [cimw_pkg::ST_COUNT-1:0] st_pins; // Raw pins as a vector

    assign st_pins = {overheat_detect_i, source_below_pack_i,
                      pack_detected_i, mains_detected_i};

    // Two flops per pin, then one for the edge
    genvar gi;
    generate
        for (gi = 0; gi < cimw_pkg::ST_COUNT; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                if (!nrst_i) begin
                    st_meta[gi] <= 1'b0;
                    st_sync[gi] <= 1'b0;
                    st_prev[gi] <= 1'b0;
                end else begin
                    st_meta[gi] <= st_pins[gi];
                    st_sync[gi] <= st_meta[gi];
                    st_prev[gi] <= st_sync[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Mode word

    logic [15:0] mode_word; // Kept bits only
    logic mode_wr; // Complete write of the mode word
    logic restore; // Restore-defaults strobe

    // The framing logic pulses valid only after the final ack
    assign mode_wr = wr_i.valid && (wr_i.cmd == cimw_pkg::CMD_MODE); // RULE15
    assign restore = mode_wr && wr_i.data[cimw_pkg::MODE_RESTORE_BIT];

    // Only a mode write touches it, so halt cannot move otherwise
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            mode_word <= cimw_pkg::MODE_RESET; // RULE12
        end else if (mode_wr) begin
            // Unused bits dropped here, never seen downstream
            mode_word <= wr_i.data & cimw_pkg::MODE_KEEP_MASK; // RULE3 RULE4 RULE14
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Setpoints

    // Restore loads defaults; zero in the bit changes nothing
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            voltage_setpoint_o <= cimw_pkg::VOLTAGE_DEFAULT;
            current_setpoint_o <= cimw_pkg::CURRENT_DEFAULT;
        end else if (restore) begin
            voltage_setpoint_o <= cimw_pkg::VOLTAGE_DEFAULT; // RULE5
            current_setpoint_o <= cimw_pkg::CURRENT_DEFAULT; // RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Overheat and alarm-block latches

    logic ovh_set; // Overheat seen
    logic ovh_clr; // Restore or pack gone

    assign ovh_set = st_sync[cimw_pkg::ST_OVERHEAT];
    assign ovh_clr = restore || !st_sync[cimw_pkg::ST_PACK];

    // Set wins over clear so a fresh event is never lost
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            overheat_latch_o <= 1'b0;
        end else if (ovh_set) begin
            overheat_latch_o <= 1'b1;
        end else if (ovh_clr) begin
            overheat_latch_o <= 1'b0; // RULE6 RULE11
        end
    end

    // Alarm-block latch, same priority
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            alarm_block_o <= 1'b0;
        end else if (alarm_set_i) begin
            alarm_block_o <= 1'b1;
        end else if (restore) begin
            alarm_block_o <= 1'b0; // RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Charger control outputs

    // One cycle behind the state; far below any analog response time
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            charge_halt_o <= 1'b0;
            charger_off_o <= 1'b0;
        end else begin
            charge_halt_o <= mode_word[cimw_pkg::MODE_HALT_BIT]; // RULE3
            charger_off_o <= mode_word[cimw_pkg::MODE_HALT_BIT] ||
                (mode_word[cimw_pkg::MODE_CUTOFF_BIT] &&
                 overheat_latch_o); // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status change interrupt

    logic [2:0] st_change; // Either edge per status bit
    logic [2:0] st_masked; // Mode mask bits in same order
    logic irq_any; // Unmasked change this cycle

    assign st_change = st_sync[2:0] ^ st_prev[2:0];
    assign st_masked = {mode_word[cimw_pkg::MODE_SOURCE_MASK_BIT],
                        mode_word[cimw_pkg::MODE_PACK_MASK_BIT],
                        mode_word[cimw_pkg::MODE_MAINS_MASK_BIT]};
    assign irq_any = |(st_change & ~st_masked); // RULE7 RULE8 RULE9

    // One-cycle pulse for each cycle that has any unmasked change
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_any;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port

    logic cap_rd; // Read of the capability word
    assign cap_rd = rd_i.valid && (rd_i.cmd == cimw_pkg::CMD_CAPABILITY);

    // Answer one cycle after request; other codes answer zero, no hit
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rd_valid_o <= 1'b0;
            rd_hit_o <= 1'b0;
            rd_data_o <= 16'h0000;
        end else begin
            rd_valid_o <= rd_i.valid; // RULE13
            rd_hit_o <= cap_rd;
            if (cap_rd) begin
                rd_data_o <= cimw_pkg::CAPABILITY_VALUE; // RULE1 RULE2
            end else begin
                rd_data_o <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_mode_wr;
        mode_wr;
    endsequence

    sequence s_restore_seen;
        restore && !ovh_set && !alarm_set_i;
    endsequence

    property p_cap_version;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        cap_rd |=> rd_valid_o && rd_hit_o &&
            rd_data_o[3:0] == cimw_pkg::SPEC_VERSION_FIELD;
    endproperty
    a_cap_version: assert property (p_cap_version) // RULE1
        else $error("Capability version field wrong");

    property p_cap_zero;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        cap_rd |=> rd_data_o[15:cimw_pkg::SELECTOR_CAPABILITY_BIT] == '0;
    endproperty
    a_cap_zero: assert property (p_cap_zero) // RULE2
        else $error("Capability upper bits not zero");

    property p_halt_follow;
        logic b;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (s_mode_wr, b = wr_i.data[0]) |=> ##1 charge_halt_o == b;
    endproperty
    a_halt_follow: assert property (p_halt_follow) // RULE3
        else $error("Halt output does not follow mode write");

    property p_halt_stable;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        !mode_wr |=> $stable(mode_word[cimw_pkg::MODE_HALT_BIT]);
    endproperty
    a_halt_stable: assert property (p_halt_stable) // RULE4
        else $error("Halt latch moved without mode write");

    property p_restore_load;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        restore |=> voltage_setpoint_o == cimw_pkg::VOLTAGE_DEFAULT &&
            current_setpoint_o == cimw_pkg::CURRENT_DEFAULT;
    endproperty
    a_restore_load: assert property (p_restore_load) // RULE5
        else $error("Restore did not load setpoints");

    property p_restore_clear;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        s_restore_seen |=> !overheat_latch_o && !alarm_block_o;
    endproperty
    a_restore_clear: assert property (p_restore_clear) // RULE6
        else $error("Restore did not clear latches");

    property p_irq_cause;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        irq_o |-> $past(irq_any);
    endproperty
    a_irq_cause: assert property (p_irq_cause) // RULE7 RULE8 RULE9
        else $error("Interrupt without unmasked change");

    property p_mains_irq;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        st_change[cimw_pkg::ST_MAINS] &&
        !mode_word[cimw_pkg::MODE_MAINS_MASK_BIT] |=> irq_o;
    endproperty
    a_mains_irq: assert property (p_mains_irq) // RULE7
        else $error("Mains change not interrupted");

    property p_cutoff;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        mode_word[cimw_pkg::MODE_CUTOFF_BIT] && overheat_latch_o
            |=> charger_off_o;
    endproperty
    a_cutoff: assert property (p_cutoff) // RULE10
        else $error("Overheat cutoff did not stop charger");

    property p_pack_clear;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        !st_sync[cimw_pkg::ST_PACK] && !ovh_set |=> !overheat_latch_o;
    endproperty
    a_pack_clear: assert property (p_pack_clear) // RULE11
        else $error("Pack absent did not clear overheat");

    property p_por_mode;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> mode_word == cimw_pkg::MODE_RESET;
    endproperty
    a_por_mode: assert property (p_por_mode) // RULE12
        else $error("Mode word wrong after reset");

    property p_keep_mask;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        s_mode_wr |=> (mode_word & ~cimw_pkg::MODE_KEEP_MASK) == '0;
    endproperty
    a_keep_mask: assert property (p_keep_mask) // RULE14
        else $error("Unimplemented mode bit stored");

endmodule

// ==== tb/cimw_host_model.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Host stand-in: hands whole transfers to the block, acknowledged or aborted
module cimw_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Transfers toward the block
    output cimw_pkg::cimw_wr_t wr_o,
    output cimw_pkg::cimw_rd_t rd_o
);
    // Idle at time zero
    initial begin
        wr_o = '0;
        rd_o = '0;
    end

    // Write-word: command, low byte, high byte, then ack
    task automatic write_word(input logic [7:0] c, input logic [15:0] d);
        @(posedge ref_clk_i);
        wr_o <= '{valid: 1'b1, cmd: c, data: d};
        @(posedge ref_clk_i);
        // Released fields show garbage, not the old value
        wr_o <= '{valid: 1'b0, cmd: ~c, data: ~d};
    endtask

    // Aborted transfer: bytes seen, never acknowledged
    task automatic abort_word(input logic [7:0] c, input logic [15:0] d);
        @(posedge ref_clk_i);
        wr_o <= '{valid: 1'b0, cmd: c, data: d};
        @(posedge ref_clk_i);
        wr_o <= '{valid: 1'b0, cmd: ~c, data: ~d};
    endtask

    // Read-word request once the command byte is known
    task automatic read_word(input logic [7:0] c);
        @(posedge ref_clk_i);
        rd_o <= '{valid: 1'b1, cmd: c};
        @(posedge ref_clk_i);
        rd_o <= '{valid: 1'b0, cmd: ~c};
    endtask
endmodule

// ==== tb/cimw_top_test.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    n_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
////////////////////////////////////////////////////////////////////////
module cimw_top_test;
    // Clock, reset, stimulus
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] st = 4'h0;
    logic alarm = 1'b0;
    cimw_pkg::cimw_wr_t wr;
    cimw_pkg::cimw_rd_t rd;
    // Outputs
    logic rv, rh, halt, off, hot, alm, irq;
    logic [15:0] rdat, volt, curr;
    // Bookkeeping
    int n_errors = 0;
    int check_count = 0;
    int irq_cnt = 0;
    int cycles = 0;
    int base;
    logic [15:0] d;
    logic [16:0] exp_q[$];
    logic [16:0] exp_v; // Oldest note, popped once per answer

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    cimw_host_model cimw_host_model_i (.ref_clk_i(clk), .wr_o(wr),
        .rd_o(rd));
    cimw_top cimw_top_i (.ref_clk_i(clk), .nrst_i(nrst), .wr_i(wr),
        .rd_i(rd), .mains_detected_i(st[0]), .pack_detected_i(st[1]),
        .source_below_pack_i(st[2]), .overheat_detect_i(st[3]),
        .alarm_set_i(alarm), .rd_valid_o(rv), .rd_hit_o(rh),
        .rd_data_o(rdat), .charge_halt_o(halt), .charger_off_o(off),
        .overheat_latch_o(hot), .alarm_block_o(alm),
        .voltage_setpoint_o(volt), .current_setpoint_o(curr),
        .irq_o(irq));

    // Read answers matched against the oldest note
    always @(posedge clk) begin
        if (rv === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(1'b1, 1'b0)
            end else begin
                // Pop once; the macro reads its arguments twice
                exp_v = exp_q.pop_front();
                `CHK({rh, rdat}, exp_v)
            end
        end
        if (irq === 1'b1) begin
            irq_cnt++;
        end
    end

    // Hang guard, well above the roughly 180 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Let registered outputs land, then sample off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wmode(input logic [15:0] v);
        cimw_host_model_i.write_word(cimw_pkg::CMD_MODE, v);
        settle(3);
    endtask

    task automatic rdq(input logic [7:0] c, input logic [16:0] e);
        exp_q.push_back(e);
        cimw_host_model_i.read_word(c);
    endtask

    // Toggle one status pin; sync plus irq takes three edges
    task automatic pin(input int k);
        @(posedge clk);
        st[k] <= ~st[k];
        settle(6);
    endtask

    task automatic pulse_alarm();
        @(posedge clk);
        alarm <= 1'b1;
        @(posedge clk);
        alarm <= 1'b0;
        settle(2);
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'h5fa1));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        settle(2);
        `CHK(volt, 16'hffff)
        `CHK(curr, 16'h00c0)
        `CHK({halt, off, irq}, 3'b000)
        // Unmasked after power-on: each change interrupts
        for (int k = 0; k < 3; k++) begin
            base = irq_cnt;
            pin(k);
            `CHK(irq_cnt, base + 1)
        end
        // Cutoff on after power-on
        pin(3);
        `CHK({hot, off}, 2'b11)
        pin(3);
        `CHK(hot, 1'b1)
        pin(1);
        `CHK({hot, off}, 2'b00)
        pin(1);
        // Capability, mode and unknown codes back to back
        rdq(cimw_pkg::CMD_CAPABILITY, 17'h1_0001);
        rdq(cimw_pkg::CMD_MODE, 17'h0_0000);
        rdq(8'h13, 17'h0_0000);
        // Halt set, then foreign and aborted writes
        wmode(16'h0401);
        `CHK({halt, off}, 2'b11)
        cimw_host_model_i.write_word(8'h13, 16'h0000);
        cimw_host_model_i.abort_word(cimw_pkg::CMD_MODE, 16'h0400);
        settle(3);
        `CHK(halt, 1'b1)
        wmode(16'h0400);
        `CHK({halt, off}, 2'b00)
        // Latches survive a plain write, restore clears them
        pin(3);
        pin(3);
        pulse_alarm();
        wmode(16'h0400);
        `CHK({hot, alm}, 2'b11)
        wmode(16'h0404);
        `CHK({hot, alm}, 2'b00)
        `CHK({volt, curr}, 32'hffff_00c0)
        // Cutoff disabled: latch alone does not stop charging
        wmode(16'h0000);
        pin(3);
        `CHK({hot, off}, 2'b10)
        pin(3);
        wmode(16'h0404);
        `CHK(hot, 1'b0)
        // All three masks set
        wmode(16'h0470);
        base = irq_cnt;
        for (int k = 0; k < 3; k++) begin
            pin(k);
        end
        `CHK(irq_cnt, base)
        // Random words: only kept bits and restore bit 2 act
        repeat (4) begin
            d = 16'($urandom);
            wmode(d);
            `CHK({halt, off}, {d[0], d[0]})
        end
        settle(2);
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule
